// [logic/plc_io_pkg.sv]
// Constants for the controller digital I/O block: register map, output
// selections, input functions and sampling timing.
// Assumes a 40 MHz system clock and a simple strobe register port.
package plc_io_pkg;

  // Register byte offsets.
  localparam logic [7:0] OUT_SEL_OFFSET = 8'h00;
  localparam logic [7:0] IN_SEL_OFFSET = 8'h04;
  localparam logic [7:0] CONFIG_OFFSET = 8'h08;
  localparam logic [7:0] MACHINE_OFFSET = 8'h0c;
  localparam logic [7:0] INPUT_OFFSET = 8'h10;
  localparam logic [7:0] COMMAND_OFFSET = 8'h14;

  // Output selection codes, 4 bits per relay.
  localparam logic [3:0] OSEL_TRIGGER1 = 4'h0;
  localparam logic [3:0] OSEL_ZERO = 4'h1;
  localparam logic [3:0] OSEL_READY = 4'h2;
  localparam logic [3:0] OSEL_CAL_ACTIVE = 4'h3;
  localparam logic [3:0] OSEL_CAL_REQUEST = 4'h4;
  localparam logic [3:0] OSEL_FAIL = 4'h5;
  localparam logic [3:0] OSEL_WARNING = 4'h6;
  localparam logic [3:0] OSEL_PURGE = 4'h7;
  localparam logic [3:0] OSEL_OPEN = 4'h8;
  localparam logic [3:0] OSEL_CLOSED = 4'h9;
  localparam logic [3:0] OSEL_RECORDER = 4'ha;
  localparam logic [3:0] OSEL_PUMP_DOWN = 4'hb;
  localparam logic [3:0] OSEL_STANDBY = 4'hc;
  localparam logic [3:0] OSEL_VENTED = 4'hd;
  localparam logic [3:0] OSEL_EMISSION = 4'he;

  // Input function codes, 3 bits per input pin.
  localparam logic [2:0] ISEL_ZERO = 3'h0;
  localparam logic [2:0] ISEL_START = 3'h1;
  localparam logic [2:0] ISEL_STOP = 3'h2;
  localparam logic [2:0] ISEL_PURGE = 3'h3;
  localparam logic [2:0] ISEL_CLEAR = 3'h4;
  localparam logic [2:0] ISEL_CAL = 3'h5;
  localparam logic [2:0] ISEL_CAL_INT = 3'h6;
  localparam logic [2:0] ISEL_CAL_EXT = 3'h7;

  // Control location codes.
  localparam logic [1:0] LOC_LOCAL = 2'h0;
  localparam logic [1:0] LOC_PLC = 2'h1;
  localparam logic [1:0] LOC_ALL = 2'h2;
  localparam logic [1:0] LOC_LOCAL_PLC = 2'h3;

  // Field positions in the config register.
  localparam int CFG_PERIOD_LSB = 0;
  localparam int CFG_LOC_LSB = 8;
  localparam int CFG_REC_LR_BIT = 10;

  // Field positions in the machine state register.
  localparam int MS_EMISSION = 0;
  localparam int MS_ERROR = 1;
  localparam int MS_WARNING = 2;
  localparam int MS_MEASURING = 3;
  localparam int MS_STANDBY = 4;
  localparam int MS_VENTED = 5;
  localparam int MS_PUMP_DOWN = 6;
  localparam int MS_CAL_ACTIVE = 7;
  localparam int MS_CAL_REQUEST = 8;
  localparam int MS_TRIGGER1 = 9;
  localparam int MS_RECORDER_BAD = 10;

  // Command bit positions.
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_VENT = 2;
  localparam int CMD_CLEAR = 3;
  localparam int CMD_CAL_INT = 4;
  localparam int CMD_CAL_EXT = 5;
  localparam int CMD_CAL_CONFIRM = 6;
  localparam int CMD_WIDTH = 7;

  // Sizes and reset values.
  localparam int NUM_OUT = 4;
  localparam int NUM_IN = 3;
  localparam logic [15:0] OUT_SEL_RESET = 16'h9876;
  localparam logic [8:0] IN_SEL_RESET = 9'h050;
  localparam logic [7:0] PERIOD_RESET_MS = 8'h0a;
  localparam logic [1:0] LOC_RESET = 2'h0;
  localparam logic [7:0] VENT_HOLD_RESET = 8'h05;

  // Sampling timing: a millisecond tick from the 40 MHz clock.
  localparam int CLOCK_HZ = 40000000;
  localparam int MS_PER_S = 1000;
  localparam int CYCLES_PER_MS = CLOCK_HZ / MS_PER_S;
  localparam logic [15:0] MS_TICK_LAST = 16'(CYCLES_PER_MS - 1);
  localparam logic [7:0] PERIOD_MIN_MS = 8'd10;
  localparam logic [7:0] PERIOD_MAX_MS = 8'd100;

endpackage : plc_io_pkg

// [logic/plc_digital_io_controller.sv]
// Digital I/O block that links the machine to an external logic controller:
// selectable relay outputs and edge-driven command inputs.
// Assumes synchronous controller inputs and a strobe register port.
//
// Behaviour
// - Zero output closes while background suppression runs.
// - Ready output closes only when measuring with emission on, no error.
// - Calibration-active output closes while any calibration runs.
// - Calibration-request output opens on a calibration request.
// - Fail output opens on error; warning output opens on warning.
// - Purge output closes while gas ballast is active.
// - Two fixed selections: always open and always closed.
// - Recorder output closes when recorder value invalid, leak-rate mode only.
// - Pump-down output opens while evacuating the test object.
// - Standby output opens in standby or vent; vented opens in vent only.
// - Emission output opens while emission is on.
// - Trigger output opens above trigger level one or when not measuring.
// - Inputs ignored unless control location is PLC, all or local+PLC.
// - Zero input rising starts suppression, falling stops it.
// - Start input rising issues start; falling does nothing.
// - Stop rising issues stop; held longer than set time also vents.
// - Purge input rising activates purge, falling deactivates it.
// - Clear input rising acknowledges the displayed error.
// - Calibration rising: internal in standby, external when measuring.
// - Calibration falling during external calibration confirms leak closed.
// - Internal calibration input rising starts internal calibration always.
// - External calibration input rising starts external; falling confirms.
// - Inputs sampled at a period adjustable from 10 to 100 ms.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps

module plc_digital_io_controller
#(
  // Last count of the millisecond divider; a bench may shorten the tick.
  parameter logic [15:0] MS_TICK_END = plc_io_pkg::MS_TICK_LAST
)
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WRITE,
  input wire logic READ,
  output logic [31:0] RDATA,
  input wire logic [plc_io_pkg::NUM_IN-1:0] PLC_IN,
  output logic [plc_io_pkg::NUM_OUT-1:0] RELAY_CLOSED,
  output logic ZERO_ACTIVE,
  output logic PURGE_ACTIVE,
  output logic [plc_io_pkg::CMD_WIDTH-1:0] COMMAND
);
  import plc_io_pkg::*;

  logic [15:0] out_sel_reg;
  logic [8:0] in_sel_reg;
  logic [7:0] period_reg;
  logic [1:0] loc_reg;
  logic rec_lr_reg;
  logic [7:0] vent_hold_reg;
  logic [10:0] machine_reg;
  logic [NUM_IN-1:0] sample_reg;
  logic [NUM_IN-1:0] prev_reg;
  logic [15:0] ms_count_reg;
  logic ms_tick;
  logic [7:0] period_count_reg;
  logic sample_tick;
  logic [7:0] period_eff;
  logic plc_allowed;
  logic [7:0] stop_hold_reg;
  logic stop_armed_reg;
  logic ext_cal_reg;
  logic [CMD_WIDTH-1:0] cmd_next;
  logic zero_next;
  logic purge_next;
  logic ext_cal_next;
  logic stop_level;
  logic stop_rise;

  // Register writes; machine state is fed in by firmware through a register.
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      out_sel_reg <= OUT_SEL_RESET;
      in_sel_reg <= IN_SEL_RESET;
      period_reg <= PERIOD_RESET_MS;
      loc_reg <= LOC_RESET;
      rec_lr_reg <= 1'b0;
      vent_hold_reg <= VENT_HOLD_RESET;
      machine_reg <= 11'h000;
    end
    else if (WRITE)
    begin
      case (ADDR)
        OUT_SEL_OFFSET: out_sel_reg <= WDATA[15:0];
        IN_SEL_OFFSET: in_sel_reg <= WDATA[8:0];
        CONFIG_OFFSET:
        begin
          period_reg <= WDATA[CFG_PERIOD_LSB +: 8];
          loc_reg <= WDATA[CFG_LOC_LSB +: 2];
          rec_lr_reg <= WDATA[CFG_REC_LR_BIT];
          vent_hold_reg <= WDATA[23:16];
        end
        MACHINE_OFFSET: machine_reg <= WDATA[10:0];
        default: ;
      endcase
    end
  end

  // Reads answer one cycle later; unmapped addresses read zero.
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      RDATA <= 32'h0000_0000;
    else if (READ)
    begin
      case (ADDR)
        OUT_SEL_OFFSET: RDATA <= {16'h0000, out_sel_reg};
        IN_SEL_OFFSET: RDATA <= {23'h000000, in_sel_reg};
        CONFIG_OFFSET: RDATA <= {8'h00, vent_hold_reg, 5'h00, rec_lr_reg,
                                 loc_reg, period_reg};
        MACHINE_OFFSET: RDATA <= {21'h000000, machine_reg};
        INPUT_OFFSET: RDATA <= {24'h000000, ext_cal_reg, PURGE_ACTIVE,
                                ZERO_ACTIVE, 2'h0, sample_reg};
        default: RDATA <= 32'h0000_0000;
      endcase
    end
    else
      RDATA <= 32'h0000_0000;
  end

  // Out-of-range settings are clamped so the period never leaves its span.
  always_comb
  begin
    if (period_reg < PERIOD_MIN_MS)
      period_eff = PERIOD_MIN_MS;
    else if (period_reg > PERIOD_MAX_MS)
      period_eff = PERIOD_MAX_MS;
    else
      period_eff = period_reg;
  end

  // Millisecond divider, then a period divider giving one-cycle sample ticks.
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      ms_count_reg <= 16'h0000;
      period_count_reg <= 8'h00;
    end
    else if (ms_count_reg == MS_TICK_END)
    begin
      ms_count_reg <= 16'h0000;
      if (period_count_reg >= period_eff - 8'h01)
        period_count_reg <= 8'h00;
      else
        period_count_reg <= period_count_reg + 8'h01;
    end
    else
      ms_count_reg <= ms_count_reg + 16'h0001;
  end

  assign ms_tick = (ms_count_reg == MS_TICK_END);
  assign sample_tick = ms_tick && (period_count_reg >= period_eff - 8'h01);

  // Inputs are only looked at on sample ticks, so short glitches pass unseen.
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      sample_reg <= '0;
      prev_reg <= '0;
    end
    else if (sample_tick)
    begin
      prev_reg <= sample_reg;
      sample_reg <= PLC_IN;
    end
  end

  assign plc_allowed = (loc_reg == LOC_PLC) || (loc_reg == LOC_ALL) ||
                       (loc_reg == LOC_LOCAL_PLC);

  // Edge decode: one pass per pin, valid only in the cycle after a sample.
  logic edge_phase_reg;
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      edge_phase_reg <= 1'b0;
    else
      edge_phase_reg <= sample_tick;
  end

  always_comb
  begin
    cmd_next = '0;
    zero_next = ZERO_ACTIVE;
    purge_next = PURGE_ACTIVE;
    ext_cal_next = ext_cal_reg;
    stop_level = 1'b0;
    stop_rise = 1'b0;
    for (int i = 0; i < NUM_IN; i++)
    begin
      logic rise;
      logic fall;
      logic [2:0] fn;
      rise = edge_phase_reg && plc_allowed && sample_reg[i] && !prev_reg[i];
      fall = edge_phase_reg && plc_allowed && !sample_reg[i] && prev_reg[i];
      fn = in_sel_reg[3*i +: 3];
      case (fn)
        ISEL_ZERO:
        begin
          if (rise)
            zero_next = 1'b1;
          if (fall)
            zero_next = 1'b0;
        end
        ISEL_START:
          if (rise)
            cmd_next[CMD_START] = 1'b1;
        ISEL_STOP:
        begin
          stop_level = stop_level | (plc_allowed && sample_reg[i]);
          if (rise)
          begin
            cmd_next[CMD_STOP] = 1'b1;
            stop_rise = 1'b1;
          end
        end
        ISEL_PURGE:
        begin
          if (rise)
            purge_next = 1'b1;
          if (fall)
            purge_next = 1'b0;
        end
        ISEL_CLEAR:
          if (rise)
            cmd_next[CMD_CLEAR] = 1'b1;
        ISEL_CAL:
        begin
          if (rise && machine_reg[MS_STANDBY])
            cmd_next[CMD_CAL_INT] = 1'b1;
          else if (rise && machine_reg[MS_MEASURING])
          begin
            cmd_next[CMD_CAL_EXT] = 1'b1;
            ext_cal_next = 1'b1;
          end
          if (fall && ext_cal_reg)
          begin
            cmd_next[CMD_CAL_CONFIRM] = 1'b1;
            ext_cal_next = 1'b0;
          end
        end
        ISEL_CAL_INT:
          if (rise)
            cmd_next[CMD_CAL_INT] = 1'b1;
        ISEL_CAL_EXT:
        begin
          if (rise)
          begin
            cmd_next[CMD_CAL_EXT] = 1'b1;
            ext_cal_next = 1'b1;
          end
          if (fall && ext_cal_reg)
          begin
            cmd_next[CMD_CAL_CONFIRM] = 1'b1;
            ext_cal_next = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // Held-stop timer counts sample periods; vent fires once per stop press.
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      stop_hold_reg <= 8'h00;
      stop_armed_reg <= 1'b0;
    end
    else if (edge_phase_reg)
    begin
      if (stop_rise)
      begin
        stop_hold_reg <= 8'h00;
        stop_armed_reg <= 1'b1;
      end
      else if (!stop_level)
        stop_armed_reg <= 1'b0;
      else if (stop_armed_reg)
      begin
        if (stop_hold_reg >= vent_hold_reg)
          stop_armed_reg <= 1'b0;
        else
          stop_hold_reg <= stop_hold_reg + 8'h01;
      end
    end
  end

  // Command pulses and function states; pulses last exactly one cycle.
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      COMMAND <= '0;
      ZERO_ACTIVE <= 1'b0;
      PURGE_ACTIVE <= 1'b0;
      ext_cal_reg <= 1'b0;
    end
    else
    begin
      COMMAND <= cmd_next;
      if (edge_phase_reg && stop_armed_reg && stop_level && !stop_rise &&
          stop_hold_reg >= vent_hold_reg)
        COMMAND[CMD_VENT] <= 1'b1;
      ZERO_ACTIVE <= zero_next;
      PURGE_ACTIVE <= purge_next;
      // A new start wins over a confirm that lands in the same sample.
      ext_cal_reg <= ext_cal_next || cmd_next[CMD_CAL_EXT];
    end
  end

  // Relay drive: a 1 closes the contact. Negative-sense selections invert.
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      RELAY_CLOSED <= '0;
    else
    begin
      for (int r = 0; r < NUM_OUT; r++)
      begin
        case (out_sel_reg[4*r +: 4])
          OSEL_TRIGGER1:
            RELAY_CLOSED[r] <= !(machine_reg[MS_TRIGGER1] ||
                                 !machine_reg[MS_MEASURING]);
          OSEL_ZERO: RELAY_CLOSED[r] <= ZERO_ACTIVE;
          OSEL_READY:
            RELAY_CLOSED[r] <= machine_reg[MS_MEASURING] &&
                               machine_reg[MS_EMISSION] &&
                               !machine_reg[MS_ERROR];
          OSEL_CAL_ACTIVE:
            RELAY_CLOSED[r] <= machine_reg[MS_CAL_ACTIVE];
          OSEL_CAL_REQUEST:
            RELAY_CLOSED[r] <= !machine_reg[MS_CAL_REQUEST];
          OSEL_FAIL: RELAY_CLOSED[r] <= !machine_reg[MS_ERROR];
          OSEL_WARNING: RELAY_CLOSED[r] <= !machine_reg[MS_WARNING];
          OSEL_PURGE: RELAY_CLOSED[r] <= PURGE_ACTIVE;
          OSEL_OPEN: RELAY_CLOSED[r] <= 1'b0;
          OSEL_CLOSED: RELAY_CLOSED[r] <= 1'b1;
          OSEL_RECORDER:
            RELAY_CLOSED[r] <= rec_lr_reg &&
                               machine_reg[MS_RECORDER_BAD];
          OSEL_PUMP_DOWN:
            RELAY_CLOSED[r] <= !machine_reg[MS_PUMP_DOWN];
          OSEL_STANDBY:
            RELAY_CLOSED[r] <= !(machine_reg[MS_STANDBY] ||
                                 machine_reg[MS_VENTED]);
          OSEL_VENTED: RELAY_CLOSED[r] <= !machine_reg[MS_VENTED];
          OSEL_EMISSION:
            RELAY_CLOSED[r] <= !machine_reg[MS_EMISSION];
          default: RELAY_CLOSED[r] <= 1'b0;
        endcase
      end
    end
  end

endmodule : plc_digital_io_controller

// [test/plc_io_asserts.sv]
// Port-level checks for the controller digital I/O block.
// Assumes the block's own port names; tracks relay 0 selection and machine
// state from the register write strobe.
`timescale 1ns/100ps

module plc_io_asserts
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WRITE,
  input wire logic READ,
  input wire logic [31:0] RDATA,
  input wire logic [plc_io_pkg::NUM_IN-1:0] PLC_IN,
  input wire logic [plc_io_pkg::NUM_OUT-1:0] RELAY_CLOSED,
  input wire logic ZERO_ACTIVE,
  input wire logic PURGE_ACTIVE,
  input wire logic [plc_io_pkg::CMD_WIDTH-1:0] COMMAND
);
  import plc_io_pkg::*;

  logic [3:0] sel_reg;
  logic [10:0] ms_reg;
  logic [1:0] quiet_reg;
  logic q;
  logic r0;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  // Shadow copies; quiet time lets the registered relays settle first.
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      sel_reg <= OUT_SEL_RESET[3:0];
      ms_reg <= '0;
      quiet_reg <= 2'h0;
    end
    else
    begin
      if (WRITE && ADDR == OUT_SEL_OFFSET)
        sel_reg <= WDATA[3:0];
      if (WRITE && ADDR == MACHINE_OFFSET)
        ms_reg <= WDATA[10:0];
      if (WRITE)
        quiet_reg <= 2'h0;
      else if (quiet_reg != 2'h3)
        quiet_reg <= quiet_reg + 2'h1;
    end
  end

  // Relay 0 stands for all four, the bench loads them alike in the relay sweep.
  assign q = (quiet_reg == 2'h3);
  assign r0 = RELAY_CLOSED[0];

  property p_fixed;
    q && (sel_reg == OSEL_OPEN || sel_reg == OSEL_CLOSED) |->
      r0 == (sel_reg == OSEL_CLOSED);
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed relay level wrong");

  property p_ready;
    q && sel_reg == OSEL_READY |-> r0 == (ms_reg[MS_EMISSION] &&
      !ms_reg[MS_ERROR] && ms_reg[MS_MEASURING]);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready relay wrong");

  property p_fail;
    q && sel_reg == OSEL_FAIL |-> r0 != ms_reg[MS_ERROR];
  endproperty
  a_fail: assert property (p_fail)
    else $error("fail relay wrong");

  property p_emis;
    q && sel_reg == OSEL_EMISSION |-> r0 != ms_reg[MS_EMISSION];
  endproperty
  a_emis: assert property (p_emis)
    else $error("emission relay wrong");

  property p_stby;
    WRITE && ADDR == OUT_SEL_OFFSET && WDATA[3:0] == OSEL_STANDBY ##1
      !WRITE [*3] |-> r0 == !(ms_reg[MS_STANDBY] || ms_reg[MS_VENTED]);
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby relay wrong");

  property p_trig;
    q && sel_reg == OSEL_TRIGGER1 |->
      r0 == (ms_reg[MS_MEASURING] && !ms_reg[MS_TRIGGER1]);
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger relay wrong");

  property p_pulse;
    COMMAND != '0 |=> COMMAND == '0;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("command longer than one cycle");

  property p_zero;
    $changed(ZERO_ACTIVE) |=> $stable(ZERO_ACTIVE) [*8];
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero state changed between samples");

  property p_rdata;
    !$past(READ) |-> RDATA == '0;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data outside its cycle");

endmodule : plc_io_asserts

// [test/plc_model.sv]
// Stand-in for the external logic controller that drives the input pins.
// The calling bench holds each level for at least one sample period.
`timescale 1ns/100ps

module plc_model
(
  input wire logic clock,
  input wire logic [plc_io_pkg::NUM_OUT-1:0] relay_closed,
  output logic [plc_io_pkg::NUM_IN-1:0] pins
);
  import plc_io_pkg::*;

  // Inputs idle low, as an unpowered controller output would be.
  initial pins = '0;

  // Levels move just after an edge and then stay put, so each requested
  // edge is clean and stable when sampled.
  task automatic drive(input logic [NUM_IN-1:0] lvl);
    @(posedge clock);
    pins <= lvl;
  endtask : drive

endmodule : plc_model

// [test/testbench.sv]
// Self-checking bench for the controller digital I/O block.
// Assumes the 40 MHz clock and a shortened millisecond tick, so each
// 10 ms sample window lasts only a hundred cycles.
`timescale 1ns/100ps

module testbench;
  import plc_io_pkg::*;

  // Ten cycles stand in for a millisecond; the margin covers output delay.
  localparam int MS_CYCLES = 10;
  localparam logic [15:0] TICK_END = 16'h0009;
  localparam int WIN = 10 * MS_CYCLES + 10;
  localparam logic [15:0] MASK [4] = '{16'h7a70, 16'h0608, 16'h3a75,
    16'h6a70};
  localparam logic [10:0] STATE [4] = '{11'h000, 11'h7ff, 11'h009, 11'h010};
  localparam logic [1:0] LOCS [3] = '{LOC_LOCAL, LOC_ALL, LOC_LOCAL_PLC};

  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic WRITE = 1'b0;
  logic READ = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [31:0] RDATA;
  logic [NUM_IN-1:0] plc_pins;
  logic [NUM_OUT-1:0] RELAY_CLOSED;
  logic ZERO_ACTIVE;
  logic PURGE_ACTIVE;
  logic [CMD_WIDTH-1:0] COMMAND;
  logic [31:0] d;
  int cnt [CMD_WIDTH];
  int mismatches = 0;
  int comparisons = 0;

  // Free-running 40 MHz clock.
  always #12.5 CLOCK = ~CLOCK;

  plc_digital_io_controller #(.MS_TICK_END(TICK_END)) uut
  (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .ADDR(ADDR),
    .WDATA(WDATA),
    .WRITE(WRITE),
    .READ(READ),
    .RDATA(RDATA),
    .PLC_IN(plc_pins),
    .RELAY_CLOSED(RELAY_CLOSED),
    .ZERO_ACTIVE(ZERO_ACTIVE),
    .PURGE_ACTIVE(PURGE_ACTIVE),
    .COMMAND(COMMAND)
  );

  plc_model plc (.clock(CLOCK), .relay_closed(RELAY_CLOSED), .pins(plc_pins));

  // Counting on change keeps the long windows cheap to simulate.
  always @(COMMAND)
    for (int b = 0; b < CMD_WIDTH; b++)
      if (COMMAND[b] === 1'b1)
        cnt[b]++;

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= v;
    WRITE <= 1'b1;
    @(posedge CLOCK);
    WRITE <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLOCK);
    ADDR <= a;
    READ <= 1'b1;
    @(posedge CLOCK);
    READ <= 1'b0;
    @(negedge CLOCK);
    v = RDATA;
  endtask : rd

  task automatic cfg(input logic [1:0] loc);
    wr(CONFIG_OFFSET, {8'h0, 8'h01, 5'h0, 1'b1, loc, PERIOD_MIN_MS});
  endtask : cfg

  // Sets the pins, then counts command pulses over whole sample windows.
  task automatic step(input logic [NUM_IN-1:0] p, input int w);
    plc.drive(p);
    cnt = '{default: 0};
    repeat (w * WIN) @(posedge CLOCK);
  endtask : step

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // Main sequence: registers, relay selections, then input commands.
  initial
  begin
    repeat (4) @(posedge CLOCK);
    RESET <= 1'b0;
    rd(OUT_SEL_OFFSET, d);
    check("out sel reset", d, {16'h0, OUT_SEL_RESET});
    rd(IN_SEL_OFFSET, d);
    check("in sel reset", d, {23'h0, IN_SEL_RESET});
    rd(CONFIG_OFFSET, d);
    check("config reset", d, {8'h0, VENT_HOLD_RESET, 6'h0, LOC_RESET,
      PERIOD_RESET_MS});
    check("relay reset", RELAY_CLOSED, 32'h9);
    cfg(LOC_PLC);
    rd(CONFIG_OFFSET, d);
    check("config", d, {16'h0001, 5'h0, 1'b1, LOC_PLC, PERIOD_MIN_MS});
    rd(8'h20, d);
    check("unmapped", d, 32'h0);
    wr(INPUT_OFFSET, 32'hffffffff);
    rd(INPUT_OFFSET, d);
    check("input read only", d, 32'h0);
    foreach (STATE[s])
    begin
      wr(MACHINE_OFFSET, {21'h0, STATE[s]});
      for (int c = 0; c < 15; c++)
      begin
        wr(OUT_SEL_OFFSET, {16'h0, {4{c[3:0]}}});
        repeat (3) @(posedge CLOCK);
        check("relay", RELAY_CLOSED, {28'h0, {4{MASK[s][c]}}});
      end
    end
    wr(OUT_SEL_OFFSET, 32'h9871);
    wr(IN_SEL_OFFSET, {23'h0, ISEL_ZERO, ISEL_STOP, ISEL_START});
    step(3'b001, 1);
    check("start", cnt[CMD_START], 1);
    step(3'b000, 1);
    check("start fall", cnt[CMD_START], 0);
    step(3'b100, 1);
    check("zero on", ZERO_ACTIVE, 1);
    check("zero relay", RELAY_CLOSED[0], 1);
    step(3'b000, 1);
    check("zero off", ZERO_ACTIVE, 0);
    step(3'b010, 3);
    check("stop", cnt[CMD_STOP], 1);
    check("vent", cnt[CMD_VENT], 1);
    step(3'b000, 1);
    check("stop fall", cnt[CMD_STOP] + cnt[CMD_VENT], 0);
    wr(IN_SEL_OFFSET, {23'h0, ISEL_CAL_INT, ISEL_CLEAR, ISEL_PURGE});
    step(3'b111, 1);
    check("purge on", PURGE_ACTIVE, 1);
    check("purge relay", RELAY_CLOSED[1], 1);
    check("clear", cnt[CMD_CLEAR], 1);
    check("cal int", cnt[CMD_CAL_INT], 1);
    step(3'b000, 1);
    check("purge off", PURGE_ACTIVE, 0);
    wr(IN_SEL_OFFSET, {23'h0, ISEL_ZERO, ISEL_CAL_EXT, ISEL_CAL});
    step(3'b001, 1);
    check("cal standby", cnt[CMD_CAL_INT], 1);
    check("cal standby ext", cnt[CMD_CAL_EXT], 0);
    step(3'b000, 1);
    check("no confirm", cnt[CMD_CAL_CONFIRM], 0);
    wr(MACHINE_OFFSET, 32'h009);
    step(3'b001, 1);
    check("cal measuring", cnt[CMD_CAL_EXT], 1);
    step(3'b000, 1);
    check("confirm", cnt[CMD_CAL_CONFIRM], 1);
    step(3'b010, 1);
    check("cal ext", cnt[CMD_CAL_EXT], 1);
    step(3'b000, 1);
    check("ext confirm", cnt[CMD_CAL_CONFIRM], 1);
    wr(IN_SEL_OFFSET, {23'h0, ISEL_ZERO, ISEL_ZERO, ISEL_START});
    foreach (LOCS[i])
    begin
      cfg(LOCS[i]);
      step(3'b001, 1);
      check("location", cnt[CMD_START], LOCS[i] != LOC_LOCAL);
      step(3'b000, 1);
    end
    wrap_up();
  end

endmodule : testbench

bind plc_digital_io_controller plc_io_asserts chk
(
  .CLOCK(CLOCK),
  .RESET(RESET),
  .ADDR(ADDR),
  .WDATA(WDATA),
  .WRITE(WRITE),
  .READ(READ),
  .RDATA(RDATA),
  .PLC_IN(PLC_IN),
  .RELAY_CLOSED(RELAY_CLOSED),
  .ZERO_ACTIVE(ZERO_ACTIVE),
  .PURGE_ACTIVE(PURGE_ACTIVE),
  .COMMAND(COMMAND)
);
